// ### obc_params.svh
// register offsets, field positions and reset values of the option byte block
`ifndef OBC_PARAMS_SVH
`define OBC_PARAMS_SVH

// apb byte offsets
`define OBC_CTRL_OFS 12'h000
`define OBC_OPT0_OFS 12'h004
`define OBC_OPT1_OFS 12'h008
`define OBC_CMD_OFS 12'h00c
`define OBC_STAT_OFS 12'h010
`define OBC_MADDR_OFS 12'h014
`define OBC_MDATA_OFS 12'h018

// clock/watchdog option byte fields
`define OBC_CKSEL_HI 7
`define OBC_CKSEL_LO 6
`define OBC_LVD_BIT 2
`define OBC_WSW_BIT 1
`define OBC_WHALT_BIT 0
`define OBC_OPT1_RES_MASK 8'h38
`define OBC_OPT1_RES_VAL 8'h28

// memory-protection option byte fields
`define OBC_OPT0_RES_MASK 8'hf0
`define OBC_SEC_HI 3
`define OBC_SEC_LO 2
`define OBC_ROP_BIT 1
`define OBC_WP_BIT 0

// shipped values
`define OBC_OPT0_RST 8'hf0
`define OBC_OPT1_RST 8'h2f
`define OBC_ERASED 8'hff

// sector 0 sizes in bytes
`define OBC_SEC_HALF_K 12'h200
`define OBC_SEC_ONE_K 12'h400
`define OBC_SEC_TWO_K 12'h800

// control and command bits
`define OBC_CTRL_PROG_BIT 0
`define OBC_CMD_OPT_ERASE_BIT 0
`define OBC_CMD_MEM_ERASE_BIT 1
`define OBC_STAT_REFUSED_BIT 1

`endif

// ### obc_pkg.sv
// types shared by the option byte block
`default_nettype none
package obc_pkg;
  typedef enum logic [1:0] {
    obc_clk_int_rc = 2'b00,
    obc_clk_wakeup_rc = 2'b01,
    obc_clk_reserved = 2'b10,
    obc_clk_external = 2'b11
  } obc_clk_sel_e;

  typedef enum logic [1:0] {
    obc_st_idle = 2'b00,
    obc_st_mem_erase = 2'b01,
    obc_st_opt_erase = 2'b10
  } obc_state_e;
endpackage
`default_nettype wire

// ### obc_decode.sv
// combinational decoder of the two option bytes
`include "obc_params.svh"
`default_nettype none
module obc_decode (
  input wire logic [7:0] mem_protect_option_byte,
  input wire logic [7:0] clock_watchdog_option_byte,
  output logic [1:0] startup_clock_select,
  output logic clk_sel_internal_rc,
  output logic clk_sel_wakeup_rc,
  output logic clk_sel_external,
  output logic low_voltage_detector_enable,
  output logic watchdog_hw_enable,
  output logic watchdog_reset_on_halt,
  output logic [11:0] sector0_size,
  output logic readout_protect,
  output logic write_protect,
  output logic reserved_bad
);
  logic [1:0] sec;

  // clock source: reserved code falls back to the internal rc
  always_comb begin
    startup_clock_select = clock_watchdog_option_byte[`OBC_CKSEL_HI:`OBC_CKSEL_LO];
    clk_sel_internal_rc = 1'b0;
    clk_sel_wakeup_rc = 1'b0;
    clk_sel_external = 1'b0;
    case (obc_pkg::obc_clk_sel_e'(startup_clock_select))
      obc_pkg::obc_clk_wakeup_rc: clk_sel_wakeup_rc = 1'b1;
      obc_pkg::obc_clk_external: clk_sel_external = 1'b1;
      default: clk_sel_internal_rc = 1'b1;
    endcase
  end

  // supervisor and watchdog options, low active detector enable
  assign low_voltage_detector_enable = ~clock_watchdog_option_byte[`OBC_LVD_BIT];
  assign watchdog_hw_enable = ~clock_watchdog_option_byte[`OBC_WSW_BIT];
  assign watchdog_reset_on_halt = clock_watchdog_option_byte[`OBC_WHALT_BIT];

  // sector 0 size, low bit set always means the largest size
  assign sec = mem_protect_option_byte[`OBC_SEC_HI:`OBC_SEC_LO];
  always_comb begin
    if (sec[0]) begin
      sector0_size = `OBC_SEC_TWO_K;
    end else if (sec[1]) begin
      sector0_size = `OBC_SEC_ONE_K;
    end else begin
      sector0_size = `OBC_SEC_HALF_K;
    end
  end

  // protection bits and a check of the fixed reserved pattern
  assign readout_protect = mem_protect_option_byte[`OBC_ROP_BIT];
  assign write_protect = mem_protect_option_byte[`OBC_WP_BIT];
  assign reserved_bad =
    ((clock_watchdog_option_byte & `OBC_OPT1_RES_MASK) != `OBC_OPT1_RES_VAL) |
    ((mem_protect_option_byte & `OBC_OPT0_RES_MASK) != `OBC_OPT0_RES_MASK);
endmodule
`default_nettype wire

// ### obc_top.sv
// option byte storage, apb programming port and latched start-up configuration
//
// Design decisions made here: the register addresses and the APB slave port.
`include "obc_params.svh"
`default_nettype none
// Function
// - the two upper clock/watchdog bits pick internal rc, wakeup rc or external clock, 10 reserved.
// - the default clock field starts the device from the internal rc oscillator.
// - clock/watchdog bit 2 at zero enables the low voltage detector, one disables it.
// - clock/watchdog bit 1 at zero makes the watchdog hardware-enabled, one leaves it to software.
// - clock/watchdog bit 0 set with an active watchdog makes halt entry cause a reset.
// - the option bytes are reachable only while programming mode is on.
// - memory-protection bits 3:2 give sector 0 as half, one or two kilobytes.
// - memory-protection bit 1 blocks read-out of program memory and refuses flash writes.
// - erasing the options under read-out protection erases all program memory first.
// - memory-protection bit 0 refuses every later erase or program of memory and options.
// - a blank device holds the erased value in every program memory byte.
module obc_top #(
  parameter int unsigned MEM_DEPTH = 2048
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic factory_blank_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_entry,
  input wire logic watchdog_active,
  output logic [1:0] startup_clock_select,
  output logic clk_sel_internal_rc,
  output logic clk_sel_wakeup_rc,
  output logic clk_sel_external,
  output logic low_voltage_detector_enable,
  output logic watchdog_hw_enable,
  output logic watchdog_reset_on_halt,
  output logic [11:0] sector0_size,
  output logic readout_protect,
  output logic write_protect,
  output logic config_valid,
  output logic halt_reset_req
);
  localparam int unsigned MW = $clog2(MEM_DEPTH);
  localparam logic [MW-1:0] LAST = MW'(MEM_DEPTH - 1);

  logic [7:0] opt0_q;
  logic [7:0] opt1_q;
  logic [7:0] mem [MEM_DEPTH];
  logic [MW-1:0] maddr_q;
  logic [MW-1:0] cnt_q;
  obc_pkg::obc_state_e state_q;
  logic then_opt_q;
  logic prog_mode_q;
  logic refused_q;
  logic ready_q;
  logic err_q;
  logic [31:0] rdata_q;
  logic err_d;
  logic [31:0] rdata_d;
  logic load_q;
  logic halt_reset_q;
  logic [1:0] d_cksel;
  logic d_int;
  logic d_wak;
  logic d_ext;
  logic d_lvd;
  logic d_wdg;
  logic d_halt;
  logic [11:0] d_sec;
  logic d_rop;
  logic d_wp;
  logic d_res_bad;
  logic reserved_bad_q;

  // live decode of the stored bytes, captured once per reset
  obc_decode u_decode (
    .mem_protect_option_byte(opt0_q),
    .clock_watchdog_option_byte(opt1_q),
    .startup_clock_select(d_cksel),
    .clk_sel_internal_rc(d_int),
    .clk_sel_wakeup_rc(d_wak),
    .clk_sel_external(d_ext),
    .low_voltage_detector_enable(d_lvd),
    .watchdog_hw_enable(d_wdg),
    .watchdog_reset_on_halt(d_halt),
    .sector0_size(d_sec),
    .readout_protect(d_rop),
    .write_protect(d_wp),
    .reserved_bad(d_res_bad)
  );

  // apb phases: one wait cycle so that every answer comes from flops
  logic access;
  logic commit;
  logic busy;
  logic sel_ctrl;
  logic sel_opt0;
  logic sel_opt1;
  logic sel_cmd;
  logic sel_stat;
  logic sel_maddr;
  logic sel_mdata;
  assign access = psel & penable;
  assign commit = access & ready_q;
  assign busy = state_q != obc_pkg::obc_st_idle;
  assign sel_ctrl = paddr == `OBC_CTRL_OFS;
  assign sel_opt0 = paddr == `OBC_OPT0_OFS;
  assign sel_opt1 = paddr == `OBC_OPT1_OFS;
  assign sel_cmd = paddr == `OBC_CMD_OFS;
  assign sel_stat = paddr == `OBC_STAT_OFS;
  assign sel_maddr = paddr == `OBC_MADDR_OFS;
  assign sel_mdata = paddr == `OBC_MDATA_OFS;

  // read data and refusal for the pending access
  always_comb begin
    rdata_d = 32'h0;
    err_d = 1'b0;
    if (sel_ctrl) begin
      rdata_d[`OBC_CTRL_PROG_BIT] = prog_mode_q;
    end else if (sel_opt0 | sel_opt1) begin
      if (!prog_mode_q) begin
        err_d = 1'b1;
      end else if (pwrite) begin
        // read-out protection refuses writes; write protection too
        err_d = busy | opt0_q[`OBC_ROP_BIT] | opt0_q[`OBC_WP_BIT] | ~pstrb[0];
      end else begin
        rdata_d[7:0] = sel_opt0 ? opt0_q : opt1_q;
      end
    end else if (sel_cmd) begin
      err_d = ~pwrite | ~prog_mode_q | busy | opt0_q[`OBC_WP_BIT];
    end else if (sel_stat) begin
      rdata_d[0] = busy;
      rdata_d[`OBC_STAT_REFUSED_BIT] = refused_q;
      rdata_d[2] = config_valid;
      rdata_d[3] = reserved_bad_q;
    end else if (sel_maddr) begin
      rdata_d[MW-1:0] = maddr_q;
    end else if (sel_mdata) begin
      // protected memory reads back as zero with an error
      if (!prog_mode_q | busy | opt0_q[`OBC_ROP_BIT]) begin
        err_d = 1'b1;
      end else if (pwrite) begin
        err_d = opt0_q[`OBC_WP_BIT] | ~pstrb[0];
      end else begin
        rdata_d[7:0] = mem[maddr_q];
      end
    end else begin
      err_d = 1'b1;
    end
  end

  // apb answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ready_q <= access & ~ready_q;
      if (access & ~ready_q) begin
        err_q <= err_d;
        rdata_q <= err_d ? 32'h0 : rdata_d;
      end
    end
  end
  assign pready = ready_q;
  assign pslverr = err_q;
  assign prdata = rdata_q;

  // programming mode, address pointer and sticky refusal flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_mode_q <= 1'b0;
      maddr_q <= '0;
      refused_q <= 1'b0;
    end else begin
      if (commit & pwrite & sel_ctrl & pstrb[0]) begin
        prog_mode_q <= pwdata[`OBC_CTRL_PROG_BIT];
      end
      if (commit & pwrite & sel_maddr & (&pstrb[1:0])) begin
        maddr_q <= pwdata[MW-1:0];
      end
      // a refusal in the clearing cycle still sets the flag
      if (commit & err_q) begin
        refused_q <= 1'b1;
      end else if (commit & pwrite & sel_stat & pwdata[`OBC_STAT_REFUSED_BIT]) begin
        refused_q <= 1'b0;
      end
    end
  end

  // option storage and erase sequencer, kept across ordinary resets
  always_ff @(posedge pclk or negedge factory_blank_n) begin
    if (!factory_blank_n) begin
      // a blank part is swept to the erased value first
      state_q <= obc_pkg::obc_st_mem_erase;
      then_opt_q <= 1'b1;
      cnt_q <= '0;
      opt0_q <= `OBC_OPT0_RST;
      opt1_q <= `OBC_OPT1_RST;
    end else begin
      case (state_q)
        obc_pkg::obc_st_idle: begin
          if (commit & pwrite & ~err_q & sel_opt0) begin
            opt0_q <= pwdata[7:0];
          end
          if (commit & pwrite & ~err_q & sel_opt1) begin
            opt1_q <= pwdata[7:0];
          end
          if (commit & pwrite & ~err_q & sel_cmd) begin
            // protected options force a full memory erase first
            if (pwdata[`OBC_CMD_OPT_ERASE_BIT] & opt0_q[`OBC_ROP_BIT]) begin
              state_q <= obc_pkg::obc_st_mem_erase;
              then_opt_q <= 1'b1;
            end else if (pwdata[`OBC_CMD_OPT_ERASE_BIT]) begin
              state_q <= obc_pkg::obc_st_opt_erase;
            end else if (pwdata[`OBC_CMD_MEM_ERASE_BIT]) begin
              state_q <= obc_pkg::obc_st_mem_erase;
              then_opt_q <= 1'b0;
            end
          end
        end
        obc_pkg::obc_st_mem_erase: begin
          cnt_q <= cnt_q + 1'b1;
          if (cnt_q == LAST) begin
            cnt_q <= '0;
            state_q <= then_opt_q ? obc_pkg::obc_st_opt_erase : obc_pkg::obc_st_idle;
          end
        end
        obc_pkg::obc_st_opt_erase: begin
          opt0_q <= `OBC_OPT0_RST;
          opt1_q <= `OBC_OPT1_RST;
          then_opt_q <= 1'b0;
          state_q <= obc_pkg::obc_st_idle;
        end
        default: state_q <= obc_pkg::obc_st_idle;
      endcase
    end
  end

  // program memory array, written by the sweep or a granted byte write
  always_ff @(posedge pclk) begin
    // erase sweep writes the erased value
    if (state_q == obc_pkg::obc_st_mem_erase) begin
      mem[cnt_q] <= `OBC_ERASED;
    end else if (commit & pwrite & ~err_q & sel_mdata) begin
      mem[maddr_q] <= pwdata[7:0];
    end
  end

  // capture the decoded options once after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_q <= 1'b1;
      config_valid <= 1'b0;
      startup_clock_select <= 2'b00;
      clk_sel_internal_rc <= 1'b0;
      clk_sel_wakeup_rc <= 1'b0;
      clk_sel_external <= 1'b0;
      low_voltage_detector_enable <= 1'b0;
      watchdog_hw_enable <= 1'b0;
      watchdog_reset_on_halt <= 1'b0;
      sector0_size <= 12'h0;
      readout_protect <= 1'b0;
      write_protect <= 1'b0;
      reserved_bad_q <= 1'b0;
    end else if (load_q) begin
      load_q <= 1'b0;
      config_valid <= 1'b1;
      // clock source from the two upper bits
      startup_clock_select <= d_cksel;
      // default and reserved codes both mean internal rc
      clk_sel_internal_rc <= d_int;
      clk_sel_wakeup_rc <= d_wak;
      clk_sel_external <= d_ext;
      // detector enable is the inverted bit
      low_voltage_detector_enable <= d_lvd;
      watchdog_hw_enable <= d_wdg;
      watchdog_reset_on_halt <= d_halt;
      sector0_size <= d_sec;
      readout_protect <= d_rop;
      write_protect <= d_wp;
      // reserved pattern flagged when the programmer broke it
      reserved_bad_q <= d_res_bad;
    end
  end

  // halt entry with an active watchdog requests a reset one cycle later when the halt option bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reset_q <= 1'b0;
    end else begin
      halt_reset_q <= halt_entry & watchdog_active & watchdog_reset_on_halt;
    end
  end
  assign halt_reset_req = halt_reset_q;

  // checks on the block's own behaviour
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_opt_erase_protected;
    commit && pwrite && sel_cmd && !err_q && !busy && pwdata[0] && opt0_q[`OBC_ROP_BIT];
  endsequence

  sequence s_sweep_start;
    (state_q == obc_pkg::obc_st_mem_erase && cnt_q == '0 && then_opt_q) ##1
    (state_q == obc_pkg::obc_st_mem_erase && cnt_q == MW'(1));
  endsequence

  a_erase_before_opt: assert property (s_opt_erase_protected |=> s_sweep_start)
    else $error("protected option erase did not start a memory sweep");

  a_rop_blocks_read: assert property (
    commit && !pwrite && sel_mdata && opt0_q[`OBC_ROP_BIT] |-> pslverr && prdata == 32'h0)
    else $error("protected memory read was not blocked");

  a_wp_keeps_opt: assert property (
    commit && pwrite && sel_opt0 && opt0_q[`OBC_WP_BIT] |=> $stable(opt0_q))
    else $error("write protected option byte changed");

  a_prog_mode_gate: assert property (
    commit && (sel_opt0 || sel_opt1) && !prog_mode_q |-> pslverr)
    else $error("option access outside programming mode accepted");

  a_config_held: assert property (
    config_valid |=> $stable(startup_clock_select) && $stable(sector0_size) &&
    $stable(readout_protect) && $stable(write_protect) && config_valid)
    else $error("latched configuration changed within a session");

  a_clock_onehot: assert property (
    config_valid |-> $onehot({clk_sel_internal_rc, clk_sel_wakeup_rc, clk_sel_external}) &&
    (clk_sel_external == (startup_clock_select == 2'b11)))
    else $error("clock source selection not decoded");

  a_clock_default: assert property (
    config_valid && startup_clock_select[0] == 1'b0 |-> clk_sel_internal_rc)
    else $error("default clock code did not select the internal rc");

  a_lvd_polarity: assert property (
    $rose(config_valid) |-> low_voltage_detector_enable == ~$past(opt1_q[`OBC_LVD_BIT]))
    else $error("detector enable has wrong polarity");

  a_wdg_type: assert property (
    $rose(config_valid) |-> watchdog_hw_enable == ~$past(opt1_q[`OBC_WSW_BIT]))
    else $error("watchdog type wrongly decoded");

  a_sector_size: assert property (
    $rose(config_valid) |-> sector0_size == ($past(opt0_q[`OBC_SEC_LO]) ? `OBC_SEC_TWO_K :
    ($past(opt0_q[`OBC_SEC_HI]) ? `OBC_SEC_ONE_K : `OBC_SEC_HALF_K)))
    else $error("sector 0 size wrongly decoded");

  a_halt_reset: assert property (
    halt_entry && watchdog_active |=> halt_reset_req == $past(watchdog_reset_on_halt))
    else $error("halt reset request does not follow the option");
endmodule
`default_nettype wire

// ### obc_prog_tool.sv
// programming tool model: apb master that loads, reads and erases the option bytes
`default_nettype none
module obc_prog_tool (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 100ps;

  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
  end

  function automatic logic [31:0] prog_word();
    return 32'h0000_0001;
  endfunction

  function automatic logic [31:0] opt1_word(input logic [1:0] ck, input logic [2:0] lo);
    return {24'h00_0000, ck, 3'b101, lo};
  endfunction

  function automatic logic [31:0] opt0_word(input logic [3:0] lo);
    return {24'h00_0000, 4'hf, lo};
  endfunction

  // one apb transfer; t is set when no answer came in time
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic t);
    int n;
    n = 0;
    t = 1'b1;
    q = 32'h0000_0000;
    e = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    while (n < 16) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        t = 1'b0;
        n = 16;
      end
      n++;
    end
    // released lines stop showing the last value
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench of the option byte block against a model of the option bytes
`include "obc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, factory_blank_n, halt_entry, watchdog_active;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w0, w1;
  logic [3:0] pstrb;
  logic [1:0] startup_clock_select;
  logic clk_sel_internal_rc, clk_sel_wakeup_rc, clk_sel_external;
  logic low_voltage_detector_enable, watchdog_hw_enable, watchdog_reset_on_halt;
  logic [11:0] sector0_size;
  logic readout_protect, write_protect, config_valid, halt_reset_req;
  int mismatches, compares, m0, m1;

  obc_top #(.MEM_DEPTH(64)) u_dut (.pclk(pclk), .presetn(presetn),
    .factory_blank_n(factory_blank_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_entry(halt_entry), .watchdog_active(watchdog_active),
    .startup_clock_select(startup_clock_select), .clk_sel_internal_rc(clk_sel_internal_rc),
    .clk_sel_wakeup_rc(clk_sel_wakeup_rc), .clk_sel_external(clk_sel_external),
    .low_voltage_detector_enable(low_voltage_detector_enable),
    .watchdog_hw_enable(watchdog_hw_enable), .watchdog_reset_on_halt(watchdog_reset_on_halt),
    .sector0_size(sector0_size), .readout_protect(readout_protect),
    .write_protect(write_protect), .config_valid(config_valid),
    .halt_reset_req(halt_reset_req));

  obc_prog_tool u_tool (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // 250 MHz clock
  always #2 pclk = ~pclk;

  // verdict and end of run
  task automatic report_and_stop();
    $display("counts: mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic hang(input string s);
    mismatches++;
    $display("BAD t=%0t %s timed out", $time, s);
    report_and_stop();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // decoded outputs against the model bytes
  task automatic chk_cfg();
    logic [7:0] a, b;
    logic [22:0] e;
    a = m0[7:0];
    b = m1[7:0];
    e = {b[7:6], b[7:6] == 2'b00 || b[7:6] == 2'b10, b[7:6] == 2'b01, b[7:6] == 2'b11,
         ~b[2], ~b[1], b[0], a[2] ? `OBC_SEC_TWO_K : (a[3] ? `OBC_SEC_ONE_K : `OBC_SEC_HALF_K),
         a[1], a[0], 1'b1};
    chk({9'h000, startup_clock_select, clk_sel_internal_rc, clk_sel_wakeup_rc,
         clk_sel_external, low_voltage_detector_enable, watchdog_hw_enable,
         watchdog_reset_on_halt, sector0_size, readout_protect, write_protect,
         config_valid}, {9'h000, e}, "config");
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic t;
    u_tool.xfer(w, a, d, rd, err, t);
    if (t === 1'b1) hang("apb");
  endtask

  task automatic wr_exp(input logic [11:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, a, d);
    chk({31'h0, err}, {31'h0, e}, "write error");
  endtask

  task automatic rd_exp(input logic [11:0] a, input logic [31:0] d, input logic e);
    bus(1'b0, a, d);
    chk({31'h0, err}, {31'h0, e}, "read error");
    chk(rd, d, "read data");
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      bus(1'b0, `OBC_STAT_OFS, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    if (n == 300) hang("busy");
  endtask

  task automatic reset_pulse();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic halt_chk();
    for (int k = 0; k < 4; k++) begin
      @(posedge pclk);
      halt_entry <= k[0];
      watchdog_active <= k[1];
      @(posedge pclk);
      #1;
      chk({31'h0, halt_reset_req}, {31'h0, k[0] & k[1] & m1[0]}, "halt reset");
    end
    @(posedge pclk);
    halt_entry <= 1'b0;
    watchdog_active <= 1'b0;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b1;
    factory_blank_n = 1'b1;
    halt_entry = 1'b0;
    watchdog_active = 1'b0;
    mismatches = 0;
    compares = 0;
    m0 = 'hf0;
    m1 = 'h2f;
    void'($urandom(98));
    // both resets fall on an edge so the asynchronous branches surely see them
    @(posedge pclk);
    presetn <= 1'b0;
    factory_blank_n <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    factory_blank_n <= 1'b1;
    wait_idle();
    chk_cfg();
    rd_exp(`OBC_OPT1_OFS, 32'h0, 1'b1);
    wr_exp(`OBC_OPT0_OFS, u_tool.opt0_word(4'h0), 1'b1);
    wr_exp(12'h0fc, 32'h0, 1'b1);
    wr_exp(`OBC_CTRL_OFS, u_tool.prog_word(), 1'b0);
    wr_exp(`OBC_MADDR_OFS, 32'($urandom_range(63)), 1'b0);
    rd_exp(`OBC_MDATA_OFS, 32'h0000_00ff, 1'b0);
    // every clock code and sector code, then halt behaviour
    for (int i = 0; i < 4; i++) begin
      wr_exp(`OBC_CTRL_OFS, u_tool.prog_word(), 1'b0);
      w1 = u_tool.opt1_word(2'(i), {2'($urandom()), i[0]});
      w0 = u_tool.opt0_word({2'(3 - i), 2'b00});
      wr_exp(`OBC_OPT1_OFS, w1, 1'b0);
      wr_exp(`OBC_OPT0_OFS, w0, 1'b0);
      rd_exp(`OBC_OPT1_OFS, w1, 1'b0);
      chk_cfg();
      m0 = int'(w0[7:0]);
      m1 = int'(w1[7:0]);
      reset_pulse();
      chk_cfg();
      halt_chk();
    end
    // read-out protection, then option erase
    wr_exp(`OBC_CTRL_OFS, u_tool.prog_word(), 1'b0);
    wr_exp(`OBC_MADDR_OFS, 32'h0000_0010, 1'b0);
    wr_exp(`OBC_MDATA_OFS, 32'h0000_005a, 1'b0);
    rd_exp(`OBC_MDATA_OFS, 32'h0000_005a, 1'b0);
    wr_exp(`OBC_OPT0_OFS, u_tool.opt0_word(4'b0010), 1'b0);
    m0 = 'hf2;
    reset_pulse();
    chk_cfg();
    wr_exp(`OBC_CTRL_OFS, u_tool.prog_word(), 1'b0);
    rd_exp(`OBC_MDATA_OFS, 32'h0, 1'b1);
    wr_exp(`OBC_MDATA_OFS, 32'h0000_0033, 1'b1);
    wr_exp(`OBC_CMD_OFS, 32'h0000_0001, 1'b0);
    wait_idle();
    rd_exp(`OBC_OPT0_OFS, 32'h0000_00f0, 1'b0);
    rd_exp(`OBC_OPT1_OFS, 32'h0000_002f, 1'b0);
    rd_exp(`OBC_MDATA_OFS, 32'h0000_00ff, 1'b0);
    // plain memory erase leaves the options alone
    wr_exp(`OBC_MDATA_OFS, 32'h0000_0077, 1'b0);
    rd_exp(`OBC_MDATA_OFS, 32'h0000_0077, 1'b0);
    wr_exp(`OBC_CMD_OFS, 32'h0000_0002, 1'b0);
    wait_idle();
    rd_exp(`OBC_MDATA_OFS, 32'h0000_00ff, 1'b0);
    rd_exp(`OBC_OPT1_OFS, 32'h0000_002f, 1'b0);
    // write protection refuses option, command and memory writes
    wr_exp(`OBC_OPT0_OFS, u_tool.opt0_word(4'b0001), 1'b0);
    m0 = 'hf1;
    m1 = 'h2f;
    reset_pulse();
    chk_cfg();
    wr_exp(`OBC_CTRL_OFS, u_tool.prog_word(), 1'b0);
    wr_exp(`OBC_OPT0_OFS, u_tool.opt0_word(4'b0000), 1'b1);
    wr_exp(`OBC_CMD_OFS, 32'h0000_0001, 1'b1);
    wr_exp(`OBC_MDATA_OFS, 32'h0000_0011, 1'b1);
    rd_exp(`OBC_OPT0_OFS, 32'h0000_00f1, 1'b0);
    // refusals are flagged sticky in status until cleared by a one
    rd_exp(`OBC_STAT_OFS, 32'h0000_0006, 1'b0);
    wr_exp(`OBC_STAT_OFS, 32'h0000_0002, 1'b0);
    rd_exp(`OBC_STAT_OFS, 32'h0000_0004, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
